//--- src/mem_port_defines.vh
// timing counts, field positions and reset values for the memory port block
`ifndef MEM_PORT_DEFINES_VH
`define MEM_PORT_DEFINES_VH
`define CLK_PERIOD_NS 25
`define ADDR_W 16
`define DATA_W 17
`define UPPER_HI 15
`define UPPER_LO 13
`define UPPER_W 3
`define REL_WIDTH_NS 260
`define REL_WIDTH_CYC ((`REL_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AH_FALL_NS 70
`define AH_FALL_CYC (`AH_FALL_NS / `CLK_PERIOD_NS)
`define RST_GAP_NS 100
`define RST_GAP_CYC ((`RST_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_CYC 8
`define ADP_RD_PERIODS 4'd4
`define ADP_WR_PERIODS 4'd2
// last counter values, sized for the 4-bit counters: 11 release cycles, 8 core cycles, 5 gap cycles
`define REL_LAST_CNT 4'd10
`define CORE_LAST_CNT 4'd7
`define RST_GAP_CNT 4'd5
`define RDATA_RST 17'h00000
`endif

//--- src/pin_sync3.v
// three-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
   parameter W = 1
) (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync,
   output wire [W-1:0] o_rise
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   integer k;
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
         o_sync <= {W{1'b0}};
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a change counts once the last two stages agree
         for (k = 0; k < W; k = k + 1) begin
            if (s2_q[k] == s3_q[k]) begin
               o_sync[k] <= s3_q[k];
            end
         end
      end
   end
   assign o_rise = (s2_q & s3_q) & ~o_sync;
endmodule
`default_nettype wire

//--- src/mem_port.v
// memory port responder: address present, request release, read data, resets
`timescale 1ns/1ps
`include "mem_port_defines.vh"
`default_nettype none
module mem_port (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_phase_a_clock,
   input wire i_mem_request,
   input wire [`ADDR_W-1:0] i_addr_lines,
   input wire i_read_select,
   input wire [`DATA_W-1:0] i_write_data_lines,
   input wire [`UPPER_W-1:0] i_start_switches,
   input wire [`UPPER_W-1:0] i_bank_limit,
   input wire i_port_disable,
   input wire i_adaptor_mode,
   input wire i_other_busy,
   input wire i_reset_button,
   output wire o_address_present_n,
   output reg o_request_release,
   output reg [`DATA_W-1:0] o_read_data_lines,
   output reg o_early_reset,
   output reg o_system_reset_line,
   output reg [`DATA_W-1:0] o_last_write_word
);
   localparam S_IDLE = 3'h0;
   localparam S_WAIT = 3'h1;
   localparam S_DELAY = 3'h2;
   localparam S_REL = 3'h3;
   localparam S_CYCLE = 3'h4;
   localparam S_DONE = 3'h5;

   wire [1:0] sync_lvl;
   wire [1:0] sync_rise;
   wire req_s = sync_lvl[0];
   wire clk_a_rise = sync_rise[1];

   pin_sync3 #(.W(2)) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_phase_a_clock, i_mem_request}),
      .o_sync(sync_lvl),
      .o_rise(sync_rise)
   );

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   reg rd_q;
   reg [`ADDR_W-1:0] addr_q;
   reg [`DATA_W-1:0] mem_q [0:7];
   reg [2:0] idx_q;
   reg ah_seen_q;
   reg rst_hold_q;
   reg [3:0] rst_cnt_q;

   wire [`UPPER_W-1:0] upper = i_addr_lines[`UPPER_HI:`UPPER_LO];
   // window of existent banks above the starting switches
   wire in_range = (upper >= i_start_switches) && (upper <= i_bank_limit);
   wire exists = i_adaptor_mode ? (upper >= i_start_switches) : in_range;
   // combinational so it drops with the request well inside 70 ns
   wire ah = i_mem_request && exists && !i_port_disable;
   assign o_address_present_n = ~ah;
   wire adp_exists = (i_addr_lines[2:0] != 3'h7);

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         S_IDLE: begin
            if (req_s && ah) begin
               state_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (!ah) begin
               state_d = S_IDLE;
            end else if (!i_other_busy && clk_a_rise) begin
               state_d = i_adaptor_mode ? S_DELAY : S_REL;
               if (!i_adaptor_mode) begin
                  cnt_d = 4'h0;
               end else if (i_read_select) begin
                  cnt_d = `ADP_RD_PERIODS;
               end else begin
                  cnt_d = `ADP_WR_PERIODS;
               end
            end
         end
         S_DELAY: begin
            if (clk_a_rise) begin
               if (cnt_q <= 4'h1) begin
                  state_d = S_REL;
                  cnt_d = 4'h0;
               end else begin
                  cnt_d = cnt_q - 4'h1;
               end
            end
         end
         S_REL: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `REL_LAST_CNT) begin
               state_d = S_CYCLE;
               cnt_d = 4'h0;
            end
         end
         S_CYCLE: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `CORE_LAST_CNT) begin
               state_d = S_DONE;
            end
         end
         S_DONE: begin
            if (!req_s) begin
               state_d = S_IDLE;
            end
         end
         default: begin
            state_d = S_IDLE;
            cnt_d = 4'h0;
         end
      endcase
   end

   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_q <= S_IDLE;
         cnt_q <= 4'h0;
         rd_q <= 1'b0;
         addr_q <= {`ADDR_W{1'b0}};
         idx_q <= 3'h0;
         ah_seen_q <= 1'b0;
         o_request_release <= 1'b0;
         o_read_data_lines <= `RDATA_RST;
         o_last_write_word <= `RDATA_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         o_request_release <= (state_d == S_REL);
         if (state_q == S_IDLE && state_d == S_WAIT) begin
            ah_seen_q <= 1'b1;
         end
         // latch request at release; adp_exists still decodes the live address lines during the core cycle
         if (state_q != S_REL && state_d == S_REL && ah_seen_q) begin
            rd_q <= i_read_select;
            addr_q <= i_addr_lines;
            idx_q <= i_addr_lines[2:0];
            if (!i_read_select) begin
               mem_q[i_addr_lines[2:0]] <= i_write_data_lines;
               o_last_write_word <= i_write_data_lines;
            end
         end
         if (state_q == S_CYCLE && cnt_q == 4'h1 && rd_q) begin
            if (i_adaptor_mode && !adp_exists) begin
               o_read_data_lines <= {`DATA_W{1'b0}};
            end else begin
               o_read_data_lines <= mem_q[idx_q];
            end
         end
         if (state_q == S_CYCLE && state_d == S_DONE) begin
            o_read_data_lines <= `RDATA_RST;
            ah_seen_q <= 1'b0;
         end
      end
   end

   // resets: rise together, system reset released a gap after early reset
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         rst_hold_q <= 1'b1;
         rst_cnt_q <= 4'h0;
         o_early_reset <= 1'b1;
         o_system_reset_line <= 1'b1;
      end else begin
         rst_hold_q <= i_reset_button;
         o_early_reset <= rst_hold_q;
         if (rst_hold_q) begin
            o_system_reset_line <= 1'b1;
            rst_cnt_q <= 4'h0;
         end else if (o_system_reset_line) begin
            if (rst_cnt_q == `RST_GAP_CNT) begin
               o_system_reset_line <= 1'b0;
            end else begin
               rst_cnt_q <= rst_cnt_q + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/mem_port_chk.sv
// assertions on the memory port pins
`timescale 1ns/1ps
`default_nettype none
module mem_port_chk (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_mem_request,
   input wire logic [15:0] i_addr_lines,
   input wire logic [2:0] i_start_switches,
   input wire logic i_port_disable,
   input wire logic i_adaptor_mode,
   input wire logic i_other_busy,
   input wire logic o_address_present_n,
   input wire logic o_request_release,
   input wire logic [16:0] o_read_data_lines,
   input wire logic o_early_reset,
   input wire logic o_system_reset_line
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire rel = o_request_release;
   wire hi = i_addr_lines[15:13] >= i_start_switches;
   property p_gate; !i_mem_request |-> o_address_present_n; endproperty
   a_gate: assert property (p_gate) else $error("present without request");
   property p_dis; i_port_disable |-> o_address_present_n; endproperty
   a_dis: assert property (p_dis) else $error("present on disabled port");
   property p_adp; i_adaptor_mode && i_mem_request && !i_port_disable && hi
      |-> !o_address_present_n; endproperty
   a_adp: assert property (p_adp) else $error("adaptor present missing");
   property p_wid; $rose(rel) |-> rel[*8] ##1 rel[*3] ##1 !rel; endproperty
   a_wid: assert property (p_wid) else $error("release width");
   property p_ans; $rose(rel) |-> !$past(o_address_present_n); endproperty
   a_ans: assert property (p_ans) else $error("release without present");
   property p_busy; $rose(rel) && !i_adaptor_mode |-> !$past(i_other_busy); endproperty
   a_busy: assert property (p_busy) else $error("release while busy");
   property p_clr; $rose(rel) |-> ##22 o_read_data_lines == 17'h00000; endproperty
   a_clr: assert property (p_clr) else $error("read data not cleared");
   property p_rst; o_early_reset |-> o_system_reset_line; endproperty
   a_rst: assert property (p_rst) else $error("reset order");
   property p_gap; $fell(o_system_reset_line) |-> !$past(o_early_reset, 4); endproperty
   a_gap: assert property (p_gap) else $error("reset gap short");
   c_rel: cover property ($rose(rel));
   c_adp: cover property (i_adaptor_mode && $rose(rel));
   c_rst: cover property ($fell(o_system_reset_line));
endmodule
bind mem_port mem_port_chk u_chk (.i_clk, .i_sys_rst, .i_mem_request, .i_addr_lines,
   .i_start_switches, .i_port_disable, .i_adaptor_mode, .i_other_busy,
   .o_address_present_n, .o_request_release, .o_read_data_lines, .o_early_reset,
   .o_system_reset_line);
`default_nettype wire

//--- tb/port_user_model.sv
// port user model: one request/release transfer per call
`timescale 1ns/1ps
`default_nettype none
module port_user_model (
   input wire logic i_clk,
   input wire logic i_phase_a_clock,
   input wire logic i_release,
   input wire logic [16:0] i_rdata,
   output logic o_req,
   output logic [15:0] o_addr,
   output logic o_rd,
   output logic [16:0] o_wdata
);
   initial begin
      o_req = 1'b0;
      o_addr = 16'h0000;
      o_rd = 1'b0;
      o_wdata = 17'h00000;
   end
   task automatic xfer(input logic rd, input logic [15:0] a, input logic [16:0] d,
         output logic ok, output int lat, output logic [16:0] q);
      lat = 0;
      @(posedge i_clk);
      o_rd <= rd;
      o_addr <= a;
      o_wdata <= rd ? 17'h00000 : d;
      @(posedge i_phase_a_clock);
      @(posedge i_clk);
      o_req <= 1'b1;
      // give up when no release comes
      while (!i_release && lat < 120) begin
         @(posedge i_clk);
         lat++;
      end
      ok = i_release;
      @(posedge i_clk);
      o_req <= 1'b0;
      repeat (4) @(posedge i_clk);
      // released lines show the inverse of their last value
      o_addr <= ~a;
      o_rd <= ~rd;
      o_wdata <= ~d;
      repeat (10) @(posedge i_clk);
      q = i_rdata;
      repeat (9) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the memory port responder
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic i_clk, i_sys_rst, ph, req, rd, rel, dis, adp, busy, btn, ah_n, erst, srst, ok;
   logic [15:0] addr;
   logic [2:0] sw;
   logic [16:0] wd, rdl, lastw, q;
   int errors, num_checks, lat;
   mem_port uut (.i_clk, .i_sys_rst, .i_phase_a_clock(ph), .i_mem_request(req),
      .i_addr_lines(addr), .i_read_select(rd), .i_write_data_lines(wd),
      .i_start_switches(sw), .i_bank_limit(3'h5), .i_port_disable(dis),
      .i_adaptor_mode(adp), .i_other_busy(busy), .i_reset_button(btn),
      .o_address_present_n(ah_n), .o_request_release(rel), .o_read_data_lines(rdl),
      .o_early_reset(erst), .o_system_reset_line(srst), .o_last_write_word(lastw));
   port_user_model pu (.i_clk, .i_phase_a_clock(ph), .i_release(rel), .i_rdata(rdl),
      .o_req(req), .o_addr(addr), .o_rd(rd), .o_wdata(wd));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   initial begin
      ph = 1'b0;
      #37;
      forever #100 ph = ~ph;
   end
   task chk(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task run(input logic r, input logic [15:0] a, input logic [16:0] d, input logic e);
      pu.xfer(r, a, d, ok, lat, q);
      chk(ok, e);
   endtask
   initial begin
      errors = 0;
      num_checks = 0;
      i_sys_rst = 1'b1;
      sw = 3'h2;
      dis = 1'b0;
      adp = 1'b0;
      busy = 1'b0;
      btn = 1'b0;
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (12) @(negedge i_clk);
      chk(erst, 0);
      chk(srst, 0);
      chk(rdl, 0);
      run(0, 16'h6005, 17'h1A5C3, 1);
      chk(lastw, 17'h1A5C3);
      chk(lat < 18, 1);
      run(1, 16'h6005, 0, 1);
      chk(q, 17'h1A5C3);
      run(0, 16'h6005, 17'h05A3C, 1);
      run(1, 16'h2001, 0, 0);
      chk(q, 0);
      dis <= 1'b1;
      run(1, 16'h6005, 0, 0);
      dis <= 1'b0;
      busy <= 1'b1;
      fork
         run(1, 16'h6005, 0, 1);
         begin
            repeat (60) @(posedge i_clk);
            chk(rel, 0);
            busy <= 1'b0;
         end
      join
      chk(q, 17'h05A3C);
      adp <= 1'b1;
      run(0, 16'hC002, 17'h0BEEF, 1);
      chk(lat > 17 && lat < 35, 1);
      run(1, 16'hC002, 0, 1);
      chk(lat > 34 && lat < 51, 1);
      chk(q, 17'h0BEEF);
      run(1, 16'hC007, 0, 1);
      chk(q, 0);
      adp <= 1'b0;
      btn <= 1'b1;
      repeat (6) @(negedge i_clk);
      chk({erst, srst}, 3);
      btn <= 1'b0;
      lat = 0;
      while (erst !== 1'b0 && lat < 100) begin
         @(negedge i_clk);
         lat++;
      end
      chk(lat < 100, 1);
      chk(srst, 1);
      repeat (6) @(negedge i_clk);
      chk(srst, 0);
      give_verdict;
   end
endmodule
`default_nettype wire
